// File: hpbb_pkg.sv
/*
 * hpbb_pkg: constants and carrier types of the host pass-through bus bridge.
 * assumes a single 25 MHz system clock shared by the bridge and its neighbours.
 */
package hpbb_pkg;
	// timing
	localparam int HPBB_CLK_NS = 40;
	localparam int HPBB_DLY_UNIT_NS = 50_000;
	localparam int HPBB_DLY_UNIT_CYC = (HPBB_DLY_UNIT_NS + HPBB_CLK_NS - 1) / HPBB_CLK_NS;
	localparam logic [5:0] HPBB_DLY_MIN = 6'h04;
	// result packet
	localparam logic [15:0] HPBB_STATUS_CODE = 16'h0005;
	localparam logic [15:0] HPBB_HDR_LEN = 16'h0009;
	localparam logic [8:0] HPBB_DATA_OFS = 9'h00D;
	localparam int HPBB_MAX_BYTES = 244;
	localparam logic [7:0] HPBB_DONE_OK = 8'h01;
	localparam logic [7:0] HPBB_DONE_ERR = 8'h02;
	// mode word bit positions
	localparam int HPBB_M_DIR = 0;
	localparam int HPBB_M_SEP = 1;
	localparam int HPBB_M_DLYEN = 2;
	localparam int HPBB_M_BUS = 3;
	localparam int HPBB_M_WIRE3 = 5;
	localparam int HPBB_M_CPOL = 6;
	localparam int HPBB_M_CPHA = 7;
	localparam int HPBB_M_DLY = 8;
	localparam int HPBB_M_CSLVL = 14;
	localparam int HPBB_M_LSB = 15;
	// command-format byte positions
	localparam int HPBB_C_SHIFT = 0;
	localparam int HPBB_C_POL = 4;
	localparam int HPBB_C_POS = 5;
	// spi clock dividers, fastest first
	localparam int HPBB_NDIV = 7;
	localparam logic [5:0] HPBB_DIV_LIST [HPBB_NDIV] = '{6'h02, 6'h03, 6'h04, 6'h06, 6'h08,
		6'h10, 6'h20};

	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] rate;
		logic [7:0] cfg;
		logic [7:0] target;
		logic [7:0] count;
		logic [7:0] reg_idx;
	} hpbb_cmd_type;

	typedef struct packed {
		logic [1:0] sel;
		logic wr;
		logic first;
		logic last;
		logic [7:0] data;
	} hpbb_mb_type;

	typedef struct packed {
		logic cpol;
		logic cpha;
		logic three_wire;
		logic low_bit_first_order;
		logic cs_level;
		logic [5:0] div;
		logic [7:0] cs_gpio;
	} hpbb_spi_type;
endpackage

// File: hpbb_bridge.sv
/*
 * hpbb_bridge: runs one bridged register read or write on a selected master bus
 * and streams back the result packet.
 * assumes command, write data, bus engine and result sink all run on sys_clk_i;
 * the byte engine answers each held request with one mb_done_i pulse.
 */
module hpbb_bridge #(
	parameter int SYS_KHZ = 25000,
	parameter int DLY_UNIT_CYC = hpbb_pkg::HPBB_DLY_UNIT_CYC
) (
	input wire logic sys_clk_i, // system clock
	input wire logic reset_i, // async reset, high
	input wire logic cmd_valid_i, // command offered
	input wire hpbb_pkg::hpbb_cmd_type cmd_i, // parsed command fields
	output logic cmd_ready_o, // bridge idle
	input wire logic wdata_valid_i, // write payload byte offered
	input wire logic [7:0] wdata_i, // write payload byte
	output logic wdata_ready_o, // payload byte taken
	input wire logic [2:0] bus_is_spi_i, // per bus: 1 spi, 0 i2c
	input wire logic [2:0] spi_locked_i, // per bus: driver set wiring
	output logic mb_req_o, // byte request, held until done
	output hpbb_pkg::hpbb_mb_type mb_o, // byte request fields
	input wire logic mb_done_i, // byte finished
	input wire logic [7:0] mb_rdata_i, // byte read
	input wire logic mb_nack_i, // i2c nack or error
	output hpbb_pkg::hpbb_spi_type spi_o, // spi setup of this transfer
	output logic [2:0] wire3_o, // per bus three wire setting
	output logic cs_pin_o, // chip select pin level
	output logic res_valid_o, // result byte valid
	output logic [7:0] res_byte_o, // result byte
	input wire logic res_ready_i // result byte taken
);
	import hpbb_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_CMDB, S_XFER, S_DELAY, S_RES} hpbb_state_type;

	hpbb_state_type state_q, state_d;
	hpbb_cmd_type cmd_q, cmd_d;
	hpbb_mb_type mb_q, mb_d;
	hpbb_spi_type spi_q, spi_d;
	logic [7:0] idx_q, idx_d;
	logic [16:0] dly_q, dly_d;
	logic [8:0] rbyte_q, rbyte_d;
	logic [2:0] wire3_q, wire3_d;
	logic nack_q, nack_d, sbus_q, sbus_d, cs_on_q, cs_on_d, mb_req_q, mb_req_d;
	logic cmd_ready_q, cmd_ready_d, wdata_ready_q, wdata_ready_d, cs_pin_q, cs_pin_d;
	logic res_valid_q, res_valid_d;
	logic [7:0] res_byte_q, res_byte_d;
	logic [7:0] mem_q [HPBB_MAX_BYTES];
	logic mem_we, rd, nack_in;
	logic [15:0] len_w;
	logic [1:0] b;
	logic [5:0] units;

	// command byte: shifted index with the read bit forced to its polarity
	function automatic logic [7:0] cmd_byte(hpbb_cmd_type c, logic is_rd);
		logic [7:0] v;
		v = c.reg_idx << c.cfg[HPBB_C_SHIFT +: 4];
		v[c.cfg[HPBB_C_POS +: 3]] = is_rd ? c.cfg[HPBB_C_POL] : ~c.cfg[HPBB_C_POL];
		return v;
	endfunction

	// fastest divider whose rate does not exceed the request; slowest if none fits
	function automatic logic [5:0] div_for(logic [15:0] rate);
		logic [5:0] d;
		logic hit;
		d = HPBB_DIV_LIST[HPBB_NDIV-1];
		hit = 1'b0;
		for (int i = 0; i < HPBB_NDIV; i++) begin
			if (!hit && (SYS_KHZ / int'(HPBB_DIV_LIST[i])) <= int'(rate)) begin
				d = HPBB_DIV_LIST[i];
				hit = 1'b1;
			end
		end
		return d;
	endfunction

	// result packet byte at position i
	function automatic logic [7:0] res_at(logic [8:0] i);
		logic [8:0] j;
		j = i - HPBB_DATA_OFS;
		case (i)
			9'h000: res_at = HPBB_STATUS_CODE[7:0];
			9'h001: res_at = HPBB_STATUS_CODE[15:8];
			9'h002: res_at = len_w[7:0];
			9'h003: res_at = len_w[15:8];
			9'h004: res_at = (nack_q || cmd_q.mode[HPBB_M_BUS +: 2] == 2'h0) ? HPBB_DONE_ERR
				: HPBB_DONE_OK;
			9'h005: res_at = cmd_q.mode[7:0];
			9'h006: res_at = cmd_q.mode[15:8];
			9'h007: res_at = sbus_q ? cmd_q.rate[7:0] : 8'h00;
			9'h008: res_at = sbus_q ? cmd_q.rate[15:8] : 8'h00;
			9'h009: res_at = cmd_q.cfg;
			9'h00A: res_at = cmd_q.target;
			9'h00B: res_at = idx_q;
			9'h00C: res_at = cmd_q.reg_idx;
			default: res_at = (rd && j < {1'b0, idx_q}) ? mem_q[j[7:0]] : 8'h00;
		endcase
	endfunction

	assign rd = ~cmd_q.mode[HPBB_M_DIR];
	assign nack_in = mb_nack_i & ~sbus_q; // spi cannot see an absent slave
	assign len_w = (HPBB_HDR_LEN + {8'h00, idx_q} + 16'h0003) & 16'hFFFC;
	assign b = cmd_i.mode[HPBB_M_BUS +: 2] - 2'h1;
	assign units = (cmd_q.mode[HPBB_M_DLY +: 6] < HPBB_DLY_MIN) ? HPBB_DLY_MIN
		: cmd_q.mode[HPBB_M_DLY +: 6]; // invalid counts 1..3 stretched to the minimum

	// next state of the whole sequencer
	always_comb begin
		state_d = state_q;
		cmd_d = cmd_q;
		idx_d = idx_q;
		nack_d = nack_q;
		sbus_d = sbus_q;
		dly_d = dly_q;
		rbyte_d = rbyte_q;
		mb_req_d = mb_req_q;
		mb_d = mb_q;
		spi_d = spi_q;
		wire3_d = wire3_q;
		cs_on_d = cs_on_q;
		res_valid_d = res_valid_q;
		res_byte_d = res_byte_q;
		mem_we = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (cmd_valid_i && cmd_ready_q) begin
					cmd_d = cmd_i;
					idx_d = 8'h00;
					nack_d = 1'b0;
					if (cmd_i.mode[HPBB_M_BUS +: 2] == 2'h0) begin
						sbus_d = 1'b0;
						state_d = S_RES;
					end else begin
						sbus_d = bus_is_spi_i[b];
						if (bus_is_spi_i[b] && !spi_locked_i[b]) begin
							wire3_d[b] = cmd_i.mode[HPBB_M_WIRE3];
						end
						// an i2c command must not move the spi chip select or its setup
						if (bus_is_spi_i[b]) begin
							spi_d.cpol = cmd_i.mode[HPBB_M_CPOL];
							spi_d.cpha = cmd_i.mode[HPBB_M_CPHA];
							spi_d.three_wire = spi_locked_i[b] ? wire3_q[b] : cmd_i.mode[HPBB_M_WIRE3];
							spi_d.low_bit_first_order = cmd_i.mode[HPBB_M_LSB];
							spi_d.cs_level = cmd_i.mode[HPBB_M_CSLVL];
							spi_d.div = div_for(cmd_i.rate);
							spi_d.cs_gpio = cmd_i.target;
						end
						mb_req_d = 1'b1;
						mb_d.sel = cmd_i.mode[HPBB_M_BUS +: 2];
						mb_d.wr = 1'b1;
						mb_d.first = 1'b1;
						mb_d.data = bus_is_spi_i[b] ? cmd_byte(cmd_i, ~cmd_i.mode[HPBB_M_DIR])
							: cmd_i.reg_idx;
						// spi read closes after the index; i2c read keeps the bus for a restart
						mb_d.last = (bus_is_spi_i[b] && !cmd_i.mode[HPBB_M_DIR])
							|| cmd_i.count == 8'h00;
						cs_on_d = bus_is_spi_i[b];
						state_d = S_CMDB;
					end
				end
			end
			S_CMDB: begin
				if (mb_done_i) begin
					mb_req_d = 1'b0;
					if (mb_q.last) cs_on_d = 1'b0;
					if (nack_in) begin
						nack_d = 1'b1;
						state_d = S_RES;
					end else if (cmd_q.count == 8'h00) begin
						state_d = S_RES;
					end else begin
						state_d = S_XFER;
					end
				end
			end
			S_XFER: begin
				if (!mb_req_q) begin
					if (rd || (wdata_valid_i && wdata_ready_q)) begin
						mb_req_d = 1'b1;
						mb_d.wr = ~rd;
						mb_d.data = rd ? 8'h00 : wdata_i;
						mb_d.first = (rd && idx_q == 8'h00) || cmd_q.mode[HPBB_M_SEP];
						mb_d.last = (idx_q == cmd_q.count - 8'h01) || cmd_q.mode[HPBB_M_SEP];
						cs_on_d = sbus_q;
					end
				end else if (mb_done_i) begin
					mb_req_d = 1'b0;
					if (mb_q.last) cs_on_d = 1'b0;
					if (nack_in) begin
						nack_d = 1'b1;
						state_d = S_RES;
					end else begin
						mem_we = rd;
						idx_d = idx_q + 8'h01;
						if (idx_q + 8'h01 == cmd_q.count) begin
							state_d = S_RES;
						end else if (cmd_q.mode[HPBB_M_DLYEN] && cmd_q.mode[HPBB_M_DLY +: 6] != 6'h00) begin
							dly_d = 17'(int'(units) * DLY_UNIT_CYC);
							state_d = S_DELAY;
						end
					end
				end
			end
			S_DELAY: begin
				dly_d = dly_q - 17'h0_0001;
				if (dly_q <= 17'h0_0001) state_d = S_XFER;
			end
			S_RES: begin
				if (res_ready_i) begin
					if (rbyte_q == 9'(len_w + 16'h0003)) begin
						res_valid_d = 1'b0;
						state_d = S_IDLE;
					end else begin
						rbyte_d = rbyte_q + 9'h001;
						res_byte_d = res_at(rbyte_q + 9'h001);
					end
				end
			end
			default: state_d = S_IDLE;
		endcase
		if (state_d == S_RES && state_q != S_RES) begin
			res_valid_d = 1'b1;
			rbyte_d = 9'h000;
			res_byte_d = HPBB_STATUS_CODE[7:0];
		end
		cmd_ready_d = (state_d == S_IDLE);
		wdata_ready_d = (state_d == S_XFER) && !mb_req_d && cmd_d.mode[HPBB_M_DIR];
		cs_pin_d = cs_on_d ? spi_d.cs_level : ~spi_d.cs_level;
	end

	// registers only
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= S_IDLE;
			cmd_q <= '0;
			idx_q <= 8'h00;
			nack_q <= 1'b0;
			sbus_q <= 1'b0;
			dly_q <= 17'h0_0000;
			rbyte_q <= 9'h000;
			mb_req_q <= 1'b0;
			mb_q <= '0;
			spi_q <= '0;
			wire3_q <= 3'h0;
			cs_on_q <= 1'b0;
			cs_pin_q <= 1'b1;
			cmd_ready_q <= 1'b0;
			wdata_ready_q <= 1'b0;
			res_valid_q <= 1'b0;
			res_byte_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			idx_q <= idx_d;
			nack_q <= nack_d;
			sbus_q <= sbus_d;
			dly_q <= dly_d;
			rbyte_q <= rbyte_d;
			mb_req_q <= mb_req_d;
			mb_q <= mb_d;
			spi_q <= spi_d;
			wire3_q <= wire3_d;
			cs_on_q <= cs_on_d;
			cs_pin_q <= cs_pin_d;
			cmd_ready_q <= cmd_ready_d;
			wdata_ready_q <= wdata_ready_d;
			res_valid_q <= res_valid_d;
			res_byte_q <= res_byte_d;
		end
	end

	// read buffer has no reset; only bytes below the count are ever returned
	always_ff @(posedge sys_clk_i) begin
		if (mem_we) mem_q[idx_q] <= mb_rdata_i;
	end

	assign cmd_ready_o = cmd_ready_q;
	assign wdata_ready_o = wdata_ready_q;
	assign mb_req_o = mb_req_q;
	assign mb_o = mb_q;
	assign spi_o = spi_q;
	assign wire3_o = wire3_q;
	assign cs_pin_o = cs_pin_q;
	assign res_valid_o = res_valid_q;
	assign res_byte_o = res_byte_q;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_bus_sel;
		$rose(mb_req_q) |-> mb_q.sel == cmd_q.mode[4:3] && mb_q.sel != 2'h0;
	endproperty
	a_bus_sel: assert property (p_bus_sel) else $error("request on wrong bus");
	property p_delay;
		state_q == S_DELAY && dly_q > 17'h0_0001 |=> state_q == S_DELAY && !mb_req_q;
	endproperty
	a_delay: assert property (p_delay) else $error("delay cut short");
	property p_wire_keep;
		((wire3_q ^ $past(wire3_q)) & $past(spi_locked_i)) == 3'h0;
	endproperty
	a_wire_keep: assert property (p_wire_keep) else $error("locked wiring changed");
	property p_read_bit;
		$rose(mb_req_q) && state_q == S_CMDB && sbus_q
			|-> mb_q.data[cmd_q.cfg[7:5]] == (rd ? cmd_q.cfg[4] : ~cmd_q.cfg[4]);
	endproperty
	a_read_bit: assert property (p_read_bit) else $error("read bit wrong");
	property p_spi_split;
		$rose(mb_req_q) && state_q == S_CMDB && sbus_q && rd |-> mb_q.last;
	endproperty
	a_spi_split: assert property (p_spi_split) else $error("spi index not own txn");
	property p_i2c_restart;
		$rose(mb_req_q) && state_q == S_XFER && !sbus_q && rd && idx_q == 8'h00 |-> mb_q.first;
	endproperty
	a_i2c_restart: assert property (p_i2c_restart) else $error("no restart");
	property p_status;
		res_valid_q && rbyte_q[8:1] == 8'h00
			|-> res_byte_q == (rbyte_q[0] ? HPBB_STATUS_CODE[15:8] : HPBB_STATUS_CODE[7:0]);
	endproperty
	a_status: assert property (p_status) else $error("bad status code");
	property p_pad;
		res_valid_q && res_ready_i && state_d == S_IDLE |-> rbyte_q[1:0] == 2'h3;
	endproperty
	a_pad: assert property (p_pad) else $error("packet not padded");
	property p_done;
		res_valid_q && rbyte_q == 9'h004 && sbus_q |-> res_byte_q == 8'h01;
	endproperty
	a_done: assert property (p_done) else $error("spi completion not 1");
	property p_cs;
		mb_req_q && sbus_q |-> cs_on_q && cs_pin_q == spi_q.cs_level;
	endproperty
	a_cs: assert property (p_cs) else $error("chip select idle in txn");

	c_spi_read: cover property (state_q == S_RES && sbus_q && rd && idx_q > 8'h01);
	c_i2c_nack: cover property ($rose(nack_q));
	c_delay: cover property (state_q == S_DELAY ##1 state_q == S_XFER);
endmodule // hpbb_bridge

// File: hpbb_slave_model.sv
/*
 * hpbb_slave_model: byte engine and slave device on the far side of the bridge's master bus.
 * assumes the bridge holds each request until it sees one done pulse for it.
 */
module hpbb_slave_model (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // async reset, high
	input wire logic req_i, // byte request from the bridge
	input wire hpbb_pkg::hpbb_mb_type mb_i, // request fields
	input wire logic nack_en_i, // answer every byte with a nack
	output logic done_o, // byte finished pulse
	output logic [7:0] rdata_o, // read byte
	output logic nack_o, // nack, valid with done
	output logic [7:0] last_wr_o // last byte written on the bus
);
	import hpbb_pkg::*;
	logic [1:0] wait_q;
	logic gap_q;
	logic [3:0] cnt_q;
	// three cycles per byte; the gap flag keeps a request still held after done from a second answer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
			gap_q <= 1'b0;
			wait_q <= 2'h0;
			cnt_q <= 4'h0;
			last_wr_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			gap_q <= done_o;
			if (req_i && !done_o && !gap_q) begin
				wait_q <= wait_q + 2'h1;
				if (wait_q == 2'h2) begin
					done_o <= 1'b1;
					wait_q <= 2'h0;
				end
			end
			// a written byte restarts the read pattern so read data is predictable
			if (done_o) begin
				cnt_q <= mb_i.wr ? 4'h0 : cnt_q + 4'h1;
				if (mb_i.wr) begin
					last_wr_o <= mb_i.data;
				end
			end
		end
	end
	// read data only holds with done; otherwise the inverse so stale values never match
	assign rdata_o = done_o ? {4'ha, cnt_q} : ~{4'ha, cnt_q};
	assign nack_o = done_o & nack_en_i;
endmodule // hpbb_slave_model

// File: hpbb_bridge_tb.sv
/*
 * hpbb_bridge_tb: self-checking bench of the bridge against the slave model.
 * assumes bus 1 is spi and buses 2 and 3 are i2c, all set up beforehand.
 */
module hpbb_bridge_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hpbb_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic wdata_valid_i = 1'b0;
	logic res_ready_i = 1'b0;
	logic nack_en = 1'b0;
	logic [2:0] bus_spi = 3'h1;
	logic [2:0] spi_locked = 3'h0;
	hpbb_cmd_type cmd_i = '0;
	logic [7:0] wdata_i = 8'h5a;
	logic cmd_ready_o, wdata_ready_o, mb_req_o, mb_done_i, mb_nack_i, res_valid_o, cs_pin_o;
	hpbb_mb_type mb_o;
	hpbb_spi_type spi_o;
	logic [7:0] mb_rdata_i, res_byte_o, last_wr;
	logic [2:0] wire3_o;
	logic [7:0] pkt [64];
	int np = 0;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	logic req_d = 1'b0;
	logic cs_prev = 1'b0;
	int gap_n = 0;
	int gap_last = 0;
	int cs_rel = 0;

	hpbb_bridge #(.SYS_KHZ(25000), .DLY_UNIT_CYC(2)) dut (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
		.wdata_valid_i(wdata_valid_i), .wdata_i(wdata_i), .wdata_ready_o(wdata_ready_o),
		.bus_is_spi_i(bus_spi), .spi_locked_i(spi_locked), .mb_req_o(mb_req_o), .mb_o(mb_o),
		.mb_done_i(mb_done_i), .mb_rdata_i(mb_rdata_i), .mb_nack_i(mb_nack_i), .spi_o(spi_o),
		.wire3_o(wire3_o), .cs_pin_o(cs_pin_o), .res_valid_o(res_valid_o),
		.res_byte_o(res_byte_o), .res_ready_i(res_ready_i));
	hpbb_slave_model partner (.clk_i(sys_clk_i), .rst_i(reset_i), .req_i(mb_req_o),
		.mb_i(mb_o), .nack_en_i(nack_en), .done_o(mb_done_i), .rdata_o(mb_rdata_i),
		.nack_o(mb_nack_i), .last_wr_o(last_wr));

	always #20 sys_clk_i = ~sys_clk_i;
	// sink stalls every other cycle; payload advances on each taken byte
	always @(posedge sys_clk_i) begin
		cyc++;
		res_ready_i <= ~res_ready_i;
		if (res_valid_o && res_ready_i) begin
			pkt[np] <= res_byte_o;
			np <= np + 1;
		end
		if (wdata_valid_i && wdata_ready_o) begin
			wdata_i <= wdata_i + 8'h01;
		end
		// idle cycles before each request, and chip select releases, for the timing checks
		req_d <= mb_req_o;
		gap_n <= mb_req_o ? 0 : gap_n + 1;
		if (mb_req_o && !req_d) begin
			gap_last <= gap_n;
		end
		cs_prev <= cs_pin_o;
		if (cs_prev && !cs_pin_o) begin
			cs_rel <= cs_rel + 1;
		end
		// spi tests use an active high select on bus 1
		if (mb_req_o && mb_o.sel == 2'h1) begin
			chk("cs pin in txn", 16'h0001, {15'h0000, cs_pin_o});
		end
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	// offer one command, hold it until taken, then wait for the packet to finish
	task automatic send(input hpbb_cmd_type c);
		np = 0;
		@(posedge sys_clk_i);
		cmd_i <= c;
		cmd_valid_i <= 1'b1;
		do @(negedge sys_clk_i); while (cmd_ready_o !== 1'b1);
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b0;
		do @(negedge sys_clk_i); while (cmd_ready_o !== 1'b1);
	endtask

	task automatic pkt_chk(input logic [7:0] comp, input logic [15:0] mode, input logic [15:0] rate,
		input logic [7:0] cfg, input logic [7:0] tgt, input logic [7:0] n, input logic [7:0] rg,
		input logic rd);
		logic [15:0] len;
		logic [7:0] e;
		len = (16'h0009 + {8'h00, n} + 16'h0003) & 16'hfffc;
		chk("packet size", len + 16'h0004, 16'(np));
		for (int i = 0; i < 4 + len; i++) begin
			case (i)
				0: e = 8'h05;
				1: e = 8'h00;
				2: e = len[7:0];
				3: e = len[15:8];
				4: e = comp;
				5: e = mode[7:0];
				6: e = mode[15:8];
				7: e = rate[7:0];
				8: e = rate[15:8];
				9: e = cfg;
				10: e = tgt;
				11: e = n;
				12: e = rg;
				default: e = (rd && i < 13 + n) ? 8'ha0 + 8'(i - 13) : 8'h00;
			endcase
			chk($sformatf("packet byte %0d", i), {8'h00, e}, {8'h00, pkt[i]});
		end
	endtask

	task automatic t_spi_read;
		int cs0;
		cs0 = cs_rel;
		send('{16'h4028, 16'h1388, 8'h11, 8'h05, 8'h02, 8'h12});
		chk("cs releases", 16'h0002, 16'(cs_rel - cs0));
		chk("cs idle", 16'h0000, {15'h0000, cs_pin_o});
		chk("command byte", 16'h0025, {8'h00, last_wr});
		chk("spi divider", 16'h0006, {10'h000, spi_o.div});
		chk("three wire", 16'h0001, {13'h0000, wire3_o});
		pkt_chk(8'h01, 16'h4028, 16'h1388, 8'h11, 8'h05, 8'h02, 8'h12, 1'b1);
		$display("test spi_read done");
	endtask

	task automatic t_i2c_write;
		@(posedge sys_clk_i);
		wdata_valid_i <= 1'b1;
		send('{16'h0011, 16'h0064, 8'h00, 8'h50, 8'h01, 8'h34});
		@(posedge sys_clk_i);
		wdata_valid_i <= 1'b0;
		chk("written byte", 16'h005a, {8'h00, last_wr});
		pkt_chk(8'h01, 16'h0011, 16'h0000, 8'h00, 8'h50, 8'h01, 8'h34, 1'b0);
		$display("test i2c_write done");
	endtask

	task automatic t_i2c_nack;
		@(posedge sys_clk_i);
		nack_en <= 1'b1;
		send('{16'h0018, 16'h0064, 8'h00, 8'h51, 8'h03, 8'h20});
		pkt_chk(8'h02, 16'h0018, 16'h0000, 8'h00, 8'h51, 8'h00, 8'h20, 1'b1);
		@(posedge sys_clk_i);
		nack_en <= 1'b0;
		$display("test i2c_nack done");
	endtask

	task automatic t_descriptor;
		send('{16'h0000, 16'h0000, 8'h07, 8'h00, 8'h04, 8'h10});
		pkt_chk(8'h02, 16'h0000, 16'h0000, 8'h07, 8'h00, 8'h00, 8'h10, 1'b0);
		$display("test descriptor done");
	endtask

	task automatic t_i2c_read;
		send('{16'h0010, 16'h0064, 8'h00, 8'h52, 8'h02, 8'h40});
		chk("index written", 16'h0040, {8'h00, last_wr});
		pkt_chk(8'h01, 16'h0010, 16'h0000, 8'h00, 8'h52, 8'h02, 8'h40, 1'b1);
		$display("test i2c_read done");
	endtask

	// separate writes with a too-small delay count on a bus whose wiring a driver locked
	task automatic t_spi_write;
		@(posedge sys_clk_i);
		spi_locked <= 3'h1;
		wdata_i <= 8'hc0;
		wdata_valid_i <= 1'b1;
		send('{16'h424f, 16'h0064, 8'he0, 8'h03, 8'h02, 8'h0a});
		@(posedge sys_clk_i);
		wdata_valid_i <= 1'b0;
		chk("byte gap", 16'h0009, 16'(gap_last));
		chk("last written", 16'h00c1, {8'h00, last_wr});
		chk("slowest divider", 16'h0020, {10'h000, spi_o.div});
		chk("locked wiring", 16'h0001, {15'h0000, spi_o.three_wire});
		chk("wiring kept", 16'h0001, {13'h0000, wire3_o});
		chk("clock polarity", 16'h0001, {15'h0000, spi_o.cpol});
		pkt_chk(8'h01, 16'h424f, 16'h0064, 8'he0, 8'h03, 8'h02, 8'h0a, 1'b0);
		$display("test spi_write done");
	endtask

	task automatic summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// only buses the setup enabled are ever selected
	initial begin
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		t_spi_read();
		t_i2c_write();
		t_i2c_nack();
		t_i2c_read();
		t_spi_write();
		t_descriptor();
		summarize();
	end
endmodule // hpbb_bridge_tb
